/* shared/copper_ctrl_pkg.sv */
// copper port control package: offsets, field layouts, reset values
// assumes one 40 MHz clock and a 32-bit register bus
package copper_ctrl_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // byte addresses
    localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h10;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h14;

    // hardware reset values
    localparam logic [REG_W-1:0] CTRL_HW_RST  = 16'h3060;
    // bit 7 is not a storage bit and reads zero
    localparam logic [REG_W-1:0] CTRL_WR_MASK = 16'hFF7F;

    // speed codes from the line side
    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // crossover mode codes
    localparam logic [1:0] MDI_FORCE  = 2'h0;
    localparam logic [1:0] MDIX_FORCE = 2'h1;
    localparam logic [1:0] MDI_RSVD   = 2'h2;
    localparam logic [1:0] MDI_AUTO   = 2'h3;

    // energy sensing codes
    localparam logic [1:0] ED_SENSE     = 2'h2;
    localparam logic [1:0] ED_SENSE_NLP = 2'h3;

    // control register layout, msb first
    typedef struct packed {
        logic       dis_link_pulse;
        logic [2:0] rsvd_hi;
        logic       rsvd_b11;
        logic       force_link;
        logic [1:0] energy;
        logic       rsvd_b7;
        logic [1:0] mdi_mode;
        logic       rsvd_b4;
        logic       tx_disable;
        logic       power_down;
        logic       pol_rev_dis;
        logic       jabber_dis;
    } ctrl_reg_s;

    // status register layout, msb first
    typedef struct packed {
        logic       rsvd_b15;
        logic       full_duplex;
        logic [1:0] speed;
        logic       jabber;
        logic       energy_sleep;
        logic [3:0] pair_polarity;
        logic       polarity_rev;
        logic       power_down;
        logic [1:0] applied_mdi;
        logic       mdix_status;
        logic       link_up;
    } status_reg_s;

    // line-side state, arriving from another clock
    typedef struct packed {
        logic       link_up;
        logic [1:0] speed;
        logic       full_duplex;
        logic       polarity_rev;
        logic [3:0] pair_polarity;
        logic       mdix_resolved;
        logic       energy_sleep;
        logic       jabber;
    } core_status_s;

    localparam int CORE_W = $bits(core_status_s);

endpackage : copper_ctrl_pkg

/* logic/sync_two_stage.sv */
// two flip-flop synchroniser for a bundle of levels
// assumes each bit is a slowly changing level from another clock
`timescale 1ns/1ps
module sync_two_stage #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : sync_two_stage

/* logic/copper_port_control_register.sv */
// copper port control register with avalon-mm slave access
// assumes line-side status arrives asynchronously and main control
// bits (power down, software reset) come from logic on i_clk
`timescale 1ns/1ps
module copper_port_control_register (
    // clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    // avalon-mm slave
    input  wire logic [copper_ctrl_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                        i_avs_read,
    input  wire logic                        i_avs_write,
    input  wire logic [copper_ctrl_pkg::DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]                  i_avs_byteenable,
    output logic      [copper_ctrl_pkg::DATA_W-1:0] o_avs_readdata,
    output logic                             o_avs_waitrequest,
    // main control bits
    input  wire logic                        i_main_power_down,
    input  wire logic                        i_sw_reset_req,
    // line-side status
    input  wire copper_ctrl_pkg::core_status_s i_core_status,
    // controls to the port
    output logic                             o_link_pulse_en,
    output logic                             o_link_up,
    output logic                             o_energy_sense,
    output logic                             o_energy_nlp,
    output logic                             o_mdi_auto,
    output logic                             o_mdix_force,
    output logic                             o_tx_enable,
    output logic                             o_power_down,
    output logic                             o_polarity_fix,
    output logic                             o_jabber_en,
    // reset pulses
    output logic                             o_sw_reset,
    output logic                             o_restart_an
);

    // merge bus bytes into the low 16 bits
    function automatic logic [15:0] merge_bytes(
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [15:0] res;
        res = old_val;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : merge_bytes

    function automatic logic speed_is(
        input logic [1:0] speed,
        input logic [1:0] code
    );
        return speed == code;
    endfunction : speed_is

    copper_ctrl_pkg::ctrl_reg_s    ctrl_q;
    copper_ctrl_pkg::status_reg_s  status_now;
    copper_ctrl_pkg::core_status_s core;
    logic [1:0]                    applied_mdi_q;
    logic                          pd_now;
    logic                          pd_q;
    logic                          pd_release;
    logic                          sw_rst_evt;
    logic                          ack_q;
    logic                          req;
    logic                          wr_take;
    logic                          rd_load;
    logic                          hit_ctrl;
    logic                          hit_status;
    logic [15:0]                   ctrl_wr_d;
    logic [copper_ctrl_pkg::DATA_W-1:0] readdata_q;
    logic                          link_up_rep;
    logic                          mdix_stat;
    logic                          is_10m;
    logic                          is_1000m;
    logic                          link_pulse_en_q;
    logic                          link_up_q;
    logic                          energy_sense_q;
    logic                          energy_nlp_q;
    logic                          mdi_auto_q;
    logic                          mdix_force_q;
    logic                          tx_enable_q;
    logic                          power_down_q;
    logic                          polarity_fix_q;
    logic                          jabber_en_q;
    logic                          sw_reset_q;
    logic                          restart_an_q;

    // line-side status crosses clock before use
    sync_two_stage #(
        .WIDTH (copper_ctrl_pkg::CORE_W)
    ) u_core_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_core_status),
        .o_sync   (core)
    );

    assign is_10m   = speed_is(core.speed, copper_ctrl_pkg::SPEED_10);
    assign is_1000m = speed_is(core.speed, copper_ctrl_pkg::SPEED_1000);

    // bus handshake: one wait cycle, then the answer
    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_q;
    assign wr_take           = i_avs_write & ack_q;
    assign rd_load           = i_avs_read & ~ack_q;
    assign hit_ctrl          = i_avs_address == copper_ctrl_pkg::CTRL_OFFSET;
    assign hit_status        = i_avs_address == copper_ctrl_pkg::STATUS_OFFSET;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // combined power down and its release
    assign pd_now     = ctrl_q.power_down | i_main_power_down;
    assign pd_release = pd_q & ~pd_now;
    assign sw_rst_evt = i_sw_reset_req | pd_release;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= pd_now;
        end
    end

    // storage bits only; bit 7 never holds a value
    assign ctrl_wr_d = merge_bytes(ctrl_q, i_avs_writedata, i_avs_byteenable)
                       & copper_ctrl_pkg::CTRL_WR_MASK;

    // control register; a write landing with a software reset wins
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= copper_ctrl_pkg::CTRL_HW_RST;
        end else if (wr_take && hit_ctrl) begin
            ctrl_q <= ctrl_wr_d;
        end else if (sw_rst_evt) begin
            ctrl_q.dis_link_pulse <= 1'b0;
        end
    end

    // crossover mode in force; updated only by a software reset
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            applied_mdi_q <= copper_ctrl_pkg::MDI_AUTO;
        end else if (sw_rst_evt &&
                     ctrl_q.mdi_mode != copper_ctrl_pkg::MDI_RSVD) begin
            applied_mdi_q <= ctrl_q.mdi_mode;
        end
    end

    // link state seen by the rest of the port
    always_comb begin
        link_up_rep = core.link_up;
        if (ctrl_q.force_link && !is_1000m) begin
            link_up_rep = 1'b1;
        end
    end

    // crossover status: manual modes show the applied field
    always_comb begin
        case (applied_mdi_q)
            copper_ctrl_pkg::MDI_FORCE:  mdix_stat = 1'b0;
            copper_ctrl_pkg::MDIX_FORCE: mdix_stat = 1'b1;
            default:                     mdix_stat = core.mdix_resolved;
        endcase
    end

    // status word
    always_comb begin
        status_now               = '0;
        status_now.link_up       = link_up_rep;
        status_now.mdix_status   = mdix_stat;
        status_now.applied_mdi   = applied_mdi_q;
        status_now.power_down    = pd_now;
        // single polarity bit below 1000M, one per pair at 1000M
        status_now.polarity_rev  = is_1000m ? 1'b0 : core.polarity_rev;
        status_now.pair_polarity = is_1000m ? core.pair_polarity : 4'h0;
        status_now.energy_sleep  = core.energy_sleep;
        status_now.jabber        = core.jabber;
        status_now.speed         = core.speed;
        status_now.full_duplex   = core.full_duplex;
    end

    // read data captured in the wait cycle, held through the answer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            readdata_q <= '0;
        end else if (rd_load) begin
            if (hit_ctrl) begin
                readdata_q <= {16'h0000, ctrl_q};
            end else if (hit_status) begin
                readdata_q <= {16'h0000, status_now};
            end else begin
                readdata_q <= '0;
            end
        end
    end

    assign o_avs_readdata = readdata_q;

    // registered port controls
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            link_pulse_en_q <= 1'b0;
            link_up_q       <= 1'b0;
            tx_enable_q     <= 1'b0;
            power_down_q    <= 1'b0;
        end else begin
            link_pulse_en_q <= ~ctrl_q.dis_link_pulse & ~pd_now;
            link_up_q       <= link_up_rep;
            tx_enable_q     <= ~ctrl_q.tx_disable & ~pd_now;
            power_down_q    <= pd_now;
        end
    end

    // energy sensing decode; 0x leaves both off
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            energy_sense_q <= 1'b0;
            energy_nlp_q   <= 1'b0;
        end else begin
            energy_sense_q <= ctrl_q.energy[1];
            energy_nlp_q   <= ctrl_q.energy == copper_ctrl_pkg::ED_SENSE_NLP;
        end
    end

    // crossover drive from the applied mode only
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mdi_auto_q   <= 1'b1;
            mdix_force_q <= 1'b0;
        end else begin
            mdi_auto_q   <= applied_mdi_q == copper_ctrl_pkg::MDI_AUTO;
            mdix_force_q <= applied_mdi_q == copper_ctrl_pkg::MDIX_FORCE;
        end
    end

    // polarity and jabber apply only at 10M
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            polarity_fix_q <= 1'b0;
            jabber_en_q    <= 1'b0;
        end else begin
            polarity_fix_q <= ctrl_q.pol_rev_dis & is_10m;
            jabber_en_q    <= ~ctrl_q.jabber_dis & is_10m
                              & ~core.full_duplex;
        end
    end

    // reset pulses; o_restart_an lasts one cycle, o_sw_reset as long as its cause
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sw_reset_q   <= 1'b0;
            restart_an_q <= 1'b0;
        end else begin
            sw_reset_q   <= sw_rst_evt;
            restart_an_q <= pd_release;
        end
    end

    assign o_link_pulse_en = link_pulse_en_q;
    assign o_link_up       = link_up_q;
    assign o_energy_sense  = energy_sense_q;
    assign o_energy_nlp    = energy_nlp_q;
    assign o_mdi_auto      = mdi_auto_q;
    assign o_mdix_force    = mdix_force_q;
    assign o_tx_enable     = tx_enable_q;
    assign o_power_down    = power_down_q;
    assign o_polarity_fix  = polarity_fix_q;
    assign o_jabber_en     = jabber_en_q;
    assign o_sw_reset      = sw_reset_q;
    assign o_restart_an    = restart_an_q;

endmodule : copper_port_control_register

/* tb/copper_port_control_register_assertions.sv */
// checker for the copper port control register ports
// assumes it is bound onto the register top, one clock domain
`timescale 1ns/1ps
module copper_port_control_register_assertions (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_resetn,
    // register bus
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    // control and port outputs
    input wire logic        i_main_power_down,
    input wire logic        i_sw_reset_req,
    input wire logic        o_link_pulse_en,
    input wire logic        o_energy_sense,
    input wire logic        o_energy_nlp,
    input wire logic        o_mdi_auto,
    input wire logic        o_mdix_force,
    input wire logic        o_tx_enable,
    input wire logic        o_power_down,
    input wire logic        o_sw_reset,
    input wire logic        o_restart_an
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // one wait state: the first request cycle always stalls
    chk_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
        else $error("request not stalled in its first cycle");
    chk_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("no acknowledge after one wait state");
    chk_rd_upper: assert property (o_avs_readdata[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
    chk_pd_main: assert property (i_main_power_down |=> o_power_down)
        else $error("main power down not honoured");
    // port must stay silent while powered down
    chk_pd_quiet: assert property (o_power_down |-> !o_tx_enable && !o_link_pulse_en)
        else $error("port active while powered down");
    chk_wake_reset: assert property ($fell(o_power_down) |-> o_sw_reset && o_restart_an)
        else $error("wake-up without reset and renegotiation");
    chk_an_wake: assert property (o_restart_an |-> $fell(o_power_down))
        else $error("renegotiation pulse without wake-up");
    chk_sw_req: assert property (i_sw_reset_req |=> o_sw_reset)
        else $error("software reset request lost");
    chk_sw_cause: assert property (o_sw_reset
        |-> $past(i_sw_reset_req) || $fell(o_power_down))
        else $error("reset pulse without a cause");
    // crossover mode may only move right after a reset pulse
    chk_mode_hold: assert property ($changed({o_mdi_auto, o_mdix_force})
        |-> $past(o_sw_reset)) else $error("crossover mode changed without reset");
    chk_energy_nlp: assert property (o_energy_nlp |-> o_energy_sense)
        else $error("pulse transmit without sensing");
endmodule : copper_port_control_register_assertions

bind copper_port_control_register copper_port_control_register_assertions u_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_main_power_down(i_main_power_down),
    .i_sw_reset_req(i_sw_reset_req), .o_link_pulse_en(o_link_pulse_en),
    .o_energy_sense(o_energy_sense), .o_energy_nlp(o_energy_nlp),
    .o_mdi_auto(o_mdi_auto), .o_mdix_force(o_mdix_force), .o_tx_enable(o_tx_enable),
    .o_power_down(o_power_down), .o_sw_reset(o_sw_reset), .o_restart_an(o_restart_an)
);

/* tb/copper_port_control_register_tb_top.sv */
// directed testbench for the copper port control register
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module copper_port_control_register_tb_top;
    localparam logic [7:0] CTRL_A = copper_ctrl_pkg::CTRL_OFFSET;
    localparam logic [7:0] STAT_A = copper_ctrl_pkg::STATUS_OFFSET;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [7:0]  i_avs_address = 8'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic        i_main_power_down = 1'b0;
    logic        i_sw_reset_req = 1'b0;
    copper_ctrl_pkg::core_status_s cs = '0;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest, o_link_pulse_en, o_link_up, o_energy_sense;
    logic        o_energy_nlp, o_mdi_auto, o_mdix_force, o_tx_enable, o_power_down;
    logic        o_polarity_fix, o_jabber_en, o_sw_reset, o_restart_an;
    logic [31:0] q;
    // status low bits per crossover code; reserved code keeps the old mode
    logic [31:0] st [4] = '{32'h0, 32'h6, 32'h6, 32'hC};
    int          failures = 0;
    int          compares = 0;

    always #12.5 i_clk = ~i_clk;

    copper_port_control_register dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_main_power_down(i_main_power_down), .i_sw_reset_req(i_sw_reset_req),
        .i_core_status(cs), .o_link_pulse_en(o_link_pulse_en), .o_link_up(o_link_up),
        .o_energy_sense(o_energy_sense), .o_energy_nlp(o_energy_nlp),
        .o_mdi_auto(o_mdi_auto), .o_mdix_force(o_mdix_force), .o_tx_enable(o_tx_enable),
        .o_power_down(o_power_down), .o_polarity_fix(o_polarity_fix),
        .o_jabber_en(o_jabber_en), .o_sw_reset(o_sw_reset), .o_restart_an(o_restart_an)
    );

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // holds the request until waitrequest is sampled low; the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_writedata <= d;
        i_avs_byteenable <= b;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(n, e, q);
    endtask : rd

    // control outputs follow one edge after the store
    task automatic wr(input logic [31:0] d);
        bus(1'b1, CTRL_A, d, 4'hF);
        @(posedge i_clk);
        #1;
    endtask : wr

    task automatic swr;
        @(posedge i_clk);
        i_sw_reset_req <= 1'b1;
        @(posedge i_clk);
        i_sw_reset_req <= 1'b0;
        #1;
        chk("sw reset pulse", 1'h1, o_sw_reset);
        @(posedge i_clk);
        #1;
    endtask : swr

    // line status passes two sync flops before the output register
    task automatic settle;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : settle

    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (600) @(posedge i_clk);
        failures++;
        $display("watchdog expired");
        give_verdict;
    end

    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(CTRL_A, "ctrl reset", 32'h3060);
        chk("mdi auto", 1'h1, o_mdi_auto);
        chk("link pulses", 1'h1, o_link_pulse_en);
        chk("tx enable", 1'h1, o_tx_enable);
        $display("test reset values done");
        wr(32'h0000_B72B);
        rd(CTRL_A, "ctrl write", 32'hB72B);
        chk("link pulses off", 1'h0, o_link_pulse_en);
        chk("forced link", 1'h1, o_link_up);
        chk("nlp", 1'h1, o_energy_nlp);
        chk("tx off", 1'h0, o_tx_enable);
        chk("polarity fix", 1'h1, o_polarity_fix);
        chk("jabber off", 1'h0, o_jabber_en);
        chk("mode held", 1'h1, o_mdi_auto);
        swr;
        chk("mdix", 1'h1, o_mdix_force);
        rd(CTRL_A, "ctrl after reset", 32'h372B);
        rd(STAT_A, "status manual", 32'h7);
        bus(1'b1, CTRL_A, 32'hFFFF_3000, 4'hE);
        rd(CTRL_A, "lane write", 32'h302B);
        bus(1'b1, 8'h20, 32'hFFFF, 4'hF);
        rd(8'h20, "unmapped", 32'h0);
        rd(CTRL_A, "ctrl kept", 32'h302B);
        $display("test field write done");
        for (int i = 0; i < 4; i++) begin
            wr(32'h3000 | (i << 8) | (i << 5));
            chk("sense", i >> 1, o_energy_sense);
            chk("nlp code", i == 3, o_energy_nlp);
            swr;
            chk("auto", i == 3, o_mdi_auto);
            chk("mdix code", i == 1 || i == 2, o_mdix_force);
            rd(STAT_A, "status mode", st[i]);
        end
        $display("test code tables done");
        wr(32'h3460);
        @(posedge i_clk);
        cs.speed <= copper_ctrl_pkg::SPEED_1000;
        cs.pair_polarity <= 4'hA;
        cs.polarity_rev <= 1'b1;
        settle;
        chk("gig force ignored", 1'h0, o_link_up);
        rd(STAT_A, "gig status", 32'h228C);
        @(posedge i_clk);
        cs.speed <= copper_ctrl_pkg::SPEED_10;
        settle;
        chk("jabber on", 1'h1, o_jabber_en);
        chk("polarity free", 1'h0, o_polarity_fix);
        rd(STAT_A, "10m status", 32'h2D);
        @(posedge i_clk);
        cs.full_duplex <= 1'b1;
        settle;
        chk("jabber full duplex", 1'h0, o_jabber_en);
        // 100M half duplex: forcing still applies, jabber stays off
        @(posedge i_clk);
        cs.speed <= copper_ctrl_pkg::SPEED_100;
        cs.full_duplex <= 1'b0;
        settle;
        chk("100m forced link", 1'h1, o_link_up);
        chk("100m jabber", 1'h0, o_jabber_en);
        $display("test line modes done");
        wr(32'hB064);
        chk("pd", 1'h1, o_power_down);
        @(posedge i_clk);
        i_main_power_down <= 1'b1;
        wr(32'hB060);
        chk("pd held", 1'h1, o_power_down);
        @(posedge i_clk);
        i_main_power_down <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("wake reset", 1'h1, o_sw_reset);
        chk("wake renegotiate", 1'h1, o_restart_an);
        chk("pd released", 1'h0, o_power_down);
        @(posedge i_clk);
        #1;
        chk("single pulse", 1'h0, o_sw_reset);
        rd(CTRL_A, "ctrl after wake", 32'h3060);
        wr(32'h3064);
        wr(32'h3060);
        $display("test power down done");
        give_verdict;
    end
endmodule : copper_port_control_register_tb_top
